// *** logic/icu_cfg.svh ***
`ifndef ICU_CFG_SVH
`define ICU_CFG_SVH

// register indices; the bus byte address is four times the index
`define ICU_IDX_BUF1      12'h140
`define ICU_IDX_CON1      12'h142
`define ICU_IDX_BUF2      12'h144
`define ICU_IDX_CON2      12'h146
`define ICU_IDX_IRQ_STAT  12'h148
`define ICU_IDX_IRQ_EN    12'h14a
`define ICU_IDX_CH_STEP   12'h004

// control register field positions
`define ICU_BIT_SIDL      13
`define ICU_BIT_TSEL      7
`define ICU_IEC_HI        6
`define ICU_IEC_LO        5
`define ICU_BIT_OVF       4
`define ICU_BIT_BNE       3
`define ICU_MODE_HI       2
`define ICU_MODE_LO       0

// reset values
`define ICU_CON_RST       16'h0000
`define ICU_IRQ_RST       2'h0

// sizes and prescaler terminal counts
`define ICU_NCH           2
`define ICU_DATA_W        16
`define ICU_FIFO_DEPTH    4
`define ICU_FIFO_CNT_W    3
`define ICU_PRE_W         4
`define ICU_PRE4_TOP      4'h3
`define ICU_PRE16_TOP     4'hf

`endif

// *** logic/icu_pkg.sv ***
`default_nettype none

package icu_pkg;

	typedef enum logic [2:0] {
		ICU_OFF      = 3'b000,
		ICU_BOTH     = 3'b001,
		ICU_FALL     = 3'b010,
		ICU_RISE     = 3'b011,
		ICU_RISE4    = 3'b100,
		ICU_RISE16   = 3'b101,
		ICU_RSVD     = 3'b110,
		ICU_IRQ_ONLY = 3'b111
	} icu_mode_t;

	typedef struct packed {
		logic      stop_in_idle;
		logic      timebase_select;
		logic [1:0] interrupt_event_count;
		icu_mode_t capture_mode_field;
	} icu_ctrl_t;

	typedef struct packed {
		logic rise;
		logic fall;
	} icu_edge_t;

	typedef struct packed {
		logic [15:0] count;
		logic        running;
	} icu_tb_t;

endpackage

`default_nettype wire

// *** logic/icu_edge.sv ***
`timescale 1ns/100ps
`default_nettype none

module icu_edge
	import icu_pkg::*;
(
	// clock and reset
	input  wire logic      pclk,
	input  wire logic      presetn,
	// asynchronous capture pin
	input  wire logic      pin,
	// one-cycle edge pulses
	output icu_edge_t      edges
);

	logic sync1_r;
	logic sync2_r;
	logic prev_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			prev_r  <= 1'b0;
		end else begin
			sync1_r <= pin;
			sync2_r <= sync1_r;
			prev_r  <= sync2_r;
		end
	end

	assign edges.rise = sync2_r & ~prev_r;
	assign edges.fall = ~sync2_r & prev_r;

endmodule

`default_nettype wire

// *** logic/icu_fifo.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "icu_cfg.svh"

module icu_fifo
	import icu_pkg::*;
(
	// clock and reset
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	// write side
	input  wire logic                         push,
	input  wire logic [`ICU_DATA_W-1:0]       din,
	// read side
	input  wire logic                         pop,
	output logic      [`ICU_DATA_W-1:0]       head,
	// status
	output logic                              full,
	output logic                              empty
);

	logic [`ICU_DATA_W-1:0]     mem_r   [`ICU_FIFO_DEPTH];
	logic [`ICU_DATA_W-1:0]     mem_nxt [`ICU_FIFO_DEPTH];
	logic [`ICU_FIFO_CNT_W-1:0] cnt_r;
	logic [`ICU_FIFO_CNT_W-1:0] cnt_nxt;
	logic [`ICU_FIFO_CNT_W-1:0] wr_idx;
	wire                        do_pop = pop & ~empty;
	wire                        do_push = push & ~full;

	assign empty  = (cnt_r == 3'h0);
	assign full   = (cnt_r == 3'(`ICU_FIFO_DEPTH));
	assign head   = mem_r[0];
	assign wr_idx = do_pop ? cnt_r - 3'h1 : cnt_r;
	assign cnt_nxt = cnt_r + {2'h0, do_push} - {2'h0, do_pop};

	// a pop moves every entry one place toward the head
	genvar g;
	generate
		for (g = 0; g < `ICU_FIFO_DEPTH; g++) begin : g_slot
			localparam int NXT = (g == `ICU_FIFO_DEPTH - 1) ? g : g + 1;
			assign mem_nxt[g] = (do_push && wr_idx == 3'(g)) ? din :
			                    do_pop ? mem_r[NXT] : mem_r[g];
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					mem_r[g] <= 16'h0000;
				else
					mem_r[g] <= mem_nxt[g];
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cnt_r <= 3'h0;
		else
			cnt_r <= cnt_nxt;
	end

endmodule

`default_nettype wire

// *** logic/icu_top.sv ***
// Operation
// RQ1 - modes: falling, rising, every 4th rising, every 16th rising, both edges
// RQ2 - edge prescaler counter clears when channel off and on reset
// RQ3 - each channel buffers captures in a four-deep 16-bit fifo
// RQ4 - buffer-not-empty set on first capture, cleared after all entries read
// RQ5 - buffer read returns oldest entry and advances the rest
// RQ6 - fifth capture into full buffer sets overflow and is dropped
// RQ7 - after overflow nothing is stored until the buffer is read empty
// RQ8 - software must not read an empty buffer; data then undefined
// RQ9 - control bit 7 selects timebase_a, else timebase_b
// RQ10 - timebase_b is the default after reset
// RQ11 - both-edge mode flags every edge, ignores event count, never overflows
// RQ12 - mode 111 with interrupt enabled wakes from sleep or idle, timer independent
// RQ13 - in sleep only mode 111 rising-edge interrupt works, no count or prescale
// RQ14 - idle keeps full function if timer runs and stop-in-idle is 0
// RQ15 - mode 111 in idle makes the pin a pure interrupt input
// RQ16 - interrupt raised after event count set by control bits 6:5
// RQ17 - per-channel flag in status register, forwarded only when enabled
// RQ18 - two independent channels, each with control and buffer registers
// RQ19 - control fields: stop-in-idle 13, select 7, count 6:5, ovf 4, bne 3, mode 2:0
// RQ20 - mode 000 off, 010 falling, 011 rising, 100 fourth, 101 sixteenth
`timescale 1ns/100ps
`default_nettype none
`include "icu_cfg.svh"

module icu_top
	import icu_pkg::*;
(
	// apb slave
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [11:0]        paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	// capture pins
	input  wire logic [1:0]         cap_pin,
	// time bases
	input  wire logic [15:0]        timebase_a_count,
	input  wire logic               timebase_a_run,
	input  wire logic [15:0]        timebase_b_count,
	input  wire logic               timebase_b_run,
	// cpu power state
	input  wire logic               cpu_sleep,
	input  wire logic               cpu_idle,
	// towards the interrupt controller
	output logic [1:0]              capture_irq,
	output logic                    wake_req
);

	// byte address of a register index
	function automatic logic [11:0] icu_addr(input logic [11:0] idx);
		icu_addr = {idx[9:0], 2'b00};
	endfunction

	function automatic logic icu_hit(input logic [11:0] a, input logic [11:0] idx);
		icu_hit = (a == icu_addr(idx));
	endfunction

	// modes that run the edge prescaler
	function automatic logic icu_pre_mode(input icu_mode_t m);
		icu_pre_mode = (m == ICU_RISE4) || (m == ICU_RISE16);
	endfunction

	// modes in which the interrupt event counter is held at zero
	function automatic logic icu_evc_idle(input icu_mode_t m);
		icu_evc_idle = (m == ICU_OFF) || (m == ICU_BOTH) || (m == ICU_IRQ_ONLY);
	endfunction

	// both-edge mode: every capture interrupts and nothing overflows
	function automatic logic icu_both(input icu_mode_t m);
		icu_both = (m == ICU_BOTH);
	endfunction

	// control fields at reset, cut from the register's reset word
	localparam logic [15:0] CON_RST  = `ICU_CON_RST;
	localparam icu_ctrl_t   CTRL_RST = '{
		stop_in_idle:          CON_RST[`ICU_BIT_SIDL],
		timebase_select:       CON_RST[`ICU_BIT_TSEL],
		interrupt_event_count: CON_RST[`ICU_IEC_HI:`ICU_IEC_LO],
		capture_mode_field:    icu_mode_t'(CON_RST[`ICU_MODE_HI:`ICU_MODE_LO])
	};

	// apb phases
	wire        setup  = psel & ~penable;
	wire        access = psel & penable;
	wire        wr_acc = access & pwrite;
	wire        rd_acc = access & ~pwrite;

	wire        hit_stat = icu_hit(paddr, `ICU_IDX_IRQ_STAT);
	wire        hit_en   = icu_hit(paddr, `ICU_IDX_IRQ_EN);
	wire        stat_wr  = wr_acc & hit_stat;
	wire        en_wr    = wr_acc & hit_en;

	// per-channel state
	icu_ctrl_t                 ctrl_r    [`ICU_NCH];
	icu_ctrl_t                 ctrl_nxt  [`ICU_NCH];
	logic                      ovf_r     [`ICU_NCH];
	logic                      ovf_nxt   [`ICU_NCH];
	logic [`ICU_PRE_W-1:0]     pre_r     [`ICU_NCH];
	logic [`ICU_PRE_W-1:0]     pre_nxt   [`ICU_NCH];
	logic [1:0]                evc_r     [`ICU_NCH];
	logic [1:0]                evc_nxt   [`ICU_NCH];
	logic [`ICU_DATA_W-1:0]    head      [`ICU_NCH];
	logic [31:0]               con_rd    [`ICU_NCH];
	logic [`ICU_NCH-1:0]       hit_buf;
	logic [`ICU_NCH-1:0]       hit_con;
	logic [`ICU_NCH-1:0]       fifo_full;
	logic [`ICU_NCH-1:0]       fifo_empty;
	logic [`ICU_NCH-1:0]       irq_set;
	logic [`ICU_NCH-1:0]       wake_set;

	// status and enable registers
	logic [`ICU_NCH-1:0]       irq_flag_r;
	logic [`ICU_NCH-1:0]       irq_flag_nxt;
	logic [`ICU_NCH-1:0]       irq_clr;
	logic [`ICU_NCH-1:0]       irq_en_r;
	logic [`ICU_NCH-1:0]       irq_en_nxt;
	logic                      wake_r;
	logic [31:0]               prdata_r;
	logic [31:0]               prdata_nxt;
	logic                      pslverr_r;
	logic                      mapped;

	genvar g;
	generate
		for (g = 0; g < `ICU_NCH; g++) begin : g_ch
			localparam logic [11:0] BUF_IDX = `ICU_IDX_BUF1 + 12'(g * 4);
			localparam logic [11:0] CON_IDX = `ICU_IDX_CON1 + 12'(g * 4);

			icu_edge_t   edges;
			icu_mode_t   mode;
			icu_tb_t     tb;
			logic        active;
			logic        irq_only;
			logic        pre_mode;
			logic        pre_tick;
			logic        pre_wrap;
			logic        raw_evt;
			logic        cap_evt;
			logic        blocked;
			logic        push;
			logic        pop;
			logic        ovf_set;
			logic        ovf_clr;
			logic        evc_hit;
			logic        con_wr;

			icu_edge u_edge (
				.pclk    (pclk),
				.presetn (presetn),
				.pin     (cap_pin[g]),
				.edges   (edges)
			);

			assign hit_buf[g] = icu_hit(paddr, BUF_IDX);
			assign hit_con[g] = icu_hit(paddr, CON_IDX);
			assign con_wr     = wr_acc & hit_con[g];
			assign mode       = ctrl_r[g].capture_mode_field;

			// select 1 picks timebase_a, 0 (reset) picks timebase_b
			assign tb.count   = ctrl_r[g].timebase_select ? timebase_a_count : timebase_b_count;  // [RQ9] [RQ10]
			assign tb.running = ctrl_r[g].timebase_select ? timebase_a_run : timebase_b_run;

			// full capture function: not asleep, and idle only with running timer
			assign active   = ~cpu_sleep & (~cpu_idle | (~ctrl_r[g].stop_in_idle & tb.running));  // [RQ13] [RQ14]
			assign irq_only = (mode == ICU_IRQ_ONLY);  // [RQ15]

			assign pre_mode = icu_pre_mode(mode);
			assign pre_wrap = (mode == ICU_RISE4) ? (pre_r[g] == `ICU_PRE4_TOP) : (pre_r[g] == `ICU_PRE16_TOP);
			assign pre_tick = edges.rise & active & pre_mode;

			always_comb begin
				case (mode)
					ICU_BOTH:   raw_evt = edges.rise | edges.fall;  // [RQ1]
					ICU_FALL:   raw_evt = edges.fall;  // [RQ20]
					ICU_RISE:   raw_evt = edges.rise;
					ICU_RISE4:  raw_evt = edges.rise & pre_wrap;  // [RQ1]
					ICU_RISE16: raw_evt = edges.rise & pre_wrap;
					default:    raw_evt = 1'b0;
				endcase
			end

			assign cap_evt = raw_evt & active;
			// after an overflow nothing is stored until the buffer has been read empty
			assign blocked = ovf_r[g] & ~fifo_empty[g];  // [RQ7]
			assign push    = cap_evt & ~fifo_full[g] & ~blocked;
			assign ovf_set = cap_evt & fifo_full[g] & ~icu_both(mode);  // [RQ6] [RQ11]
			assign ovf_clr = con_wr & ~pwdata[`ICU_BIT_OVF];
			assign pop     = rd_acc & hit_buf[g] & ~fifo_empty[g];  // [RQ5] [RQ8]

			// prescaler counter
			always_comb begin
				if (mode == ICU_OFF || !pre_mode)
					pre_nxt[g] = 4'h0;  // [RQ2]
				else if (pre_tick)
					pre_nxt[g] = pre_wrap ? 4'h0 : pre_r[g] + 4'h1;
				else
					pre_nxt[g] = pre_r[g];
			end

			// interrupt event counter: count field n raises on the (n+1)th capture
			assign evc_hit = (evc_r[g] == ctrl_r[g].interrupt_event_count);  // [RQ16]
			always_comb begin
				if (icu_evc_idle(mode))
					evc_nxt[g] = 2'h0;
				else if (push)
					evc_nxt[g] = evc_hit ? 2'h0 : evc_r[g] + 2'h1;
				else
					evc_nxt[g] = evc_r[g];
			end

			// mode 111 fires on rising edges in run, idle and sleep alike
			assign irq_set[g] = (irq_only & edges.rise) |  // [RQ12] [RQ15]
			                    (icu_both(mode) & cap_evt) |  // [RQ11]
			                    (push & ~icu_both(mode) & evc_hit);  // [RQ16]
			assign wake_set[g] = irq_only & edges.rise & irq_en_r[g] & (cpu_sleep | cpu_idle);  // [RQ12]

			// overflow is sticky; software clears by writing 0, a new overflow wins
			assign ovf_nxt[g] = ovf_set | (ovf_r[g] & ~ovf_clr);  // [RQ6]

			always_comb begin
				ctrl_nxt[g] = ctrl_r[g];
				if (con_wr) begin
					ctrl_nxt[g].stop_in_idle          = pwdata[`ICU_BIT_SIDL];  // [RQ19]
					ctrl_nxt[g].timebase_select       = pwdata[`ICU_BIT_TSEL];
					ctrl_nxt[g].interrupt_event_count = pwdata[`ICU_IEC_HI:`ICU_IEC_LO];
					ctrl_nxt[g].capture_mode_field    = icu_mode_t'(pwdata[`ICU_MODE_HI:`ICU_MODE_LO]);
				end
			end

			assign con_rd[g] = {16'h0000, 2'b00, ctrl_r[g].stop_in_idle, 5'h00,
			                    ctrl_r[g].timebase_select, ctrl_r[g].interrupt_event_count,
			                    ovf_r[g], ~fifo_empty[g], ctrl_r[g].capture_mode_field};  // [RQ4] [RQ19]

			// the fifo stores the count of the selected time base
			icu_fifo u_fifo (
				.pclk    (pclk),
				.presetn (presetn),
				.push    (push),  // [RQ3]
				.din     (tb.count),
				.pop     (pop),
				.head    (head[g]),
				.full    (fifo_full[g]),
				.empty   (fifo_empty[g])
			);

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					ctrl_r[g] <= CTRL_RST;  // [RQ10]
				else
					ctrl_r[g] <= ctrl_nxt[g];
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					ovf_r[g] <= 1'b0;
				else
					ovf_r[g] <= ovf_nxt[g];
			end

			// prescaler restarts from zero on any reset
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					pre_r[g] <= 4'h0;  // [RQ2]
				else
					pre_r[g] <= pre_nxt[g];
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					evc_r[g] <= 2'h0;
				else
					evc_r[g] <= evc_nxt[g];
			end
		end
	endgenerate

	// flags: write 1 to clear, a same-cycle set wins
	assign irq_clr      = stat_wr ? pwdata[1:0] : 2'h0;
	assign irq_flag_nxt = irq_set | (irq_flag_r & ~irq_clr);  // [RQ17]
	assign irq_en_nxt   = en_wr ? pwdata[1:0] : irq_en_r;

	// read data is latched in the setup phase and held through access
	assign mapped = (|hit_buf) | (|hit_con) | hit_stat | hit_en;  // [RQ18]
	always_comb begin
		prdata_nxt = 32'h0000_0000;
		if (hit_buf[0])
			prdata_nxt = {16'h0000, head[0]};  // [RQ5]
		else if (hit_buf[1])
			prdata_nxt = {16'h0000, head[1]};
		else if (hit_con[0])
			prdata_nxt = con_rd[0];
		else if (hit_con[1])
			prdata_nxt = con_rd[1];
		else if (hit_stat)
			prdata_nxt = {30'h0, irq_flag_r};
		else if (hit_en)
			prdata_nxt = {30'h0, irq_en_r};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_flag_r <= `ICU_IRQ_RST;
		else
			irq_flag_r <= irq_flag_nxt;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_en_r <= `ICU_IRQ_RST;
		else
			irq_en_r <= irq_en_nxt;
	end

	// wake is a registered one-cycle pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			wake_r <= 1'b0;
		else
			wake_r <= |wake_set;
	end

	// only a setup cycle loads these, so they hold through the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (setup) begin
			prdata_r  <= prdata_nxt;
			pslverr_r <= ~mapped;
		end
	end

	assign pready      = 1'b1;
	assign prdata      = prdata_r;
	assign pslverr     = pslverr_r & access;
	assign capture_irq = irq_flag_r & irq_en_r;  // [RQ17]
	assign wake_req    = wake_r;

endmodule

`default_nettype wire

// *** sim/icu_src.sv ***
`timescale 1ns/100ps
`default_nettype none

module icu_src (
	// clock
	input  wire logic       pclk,
	// pulse request and its channel
	input  wire logic       go,
	input  wire logic       ch,
	// capture pins and progress
	output logic      [1:0] pin,
	output logic            busy
);
	int   t_r = 0;
	logic c_r = 1'h0;

	initial pin = 2'h0;
	initial busy = 1'h0;
	// one clean pulse, each level held eight cycles so the synchroniser sees it
	always @(posedge pclk) begin
		if (go && !busy) begin
			busy <= 1'h1;
			c_r <= ch;
		end
		if (busy)
			t_r <= t_r + 1;
		if (busy && t_r == 0)
			pin[c_r] <= 1'h1;
		if (t_r == 8)
			pin[c_r] <= 1'h0;
		if (t_r == 16) begin
			busy <= 1'h0;
			t_r <= 0;
		end
	end
endmodule

`default_nettype wire

// *** sim/icu_top_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "icu_cfg.svh"

module icu_top_chk (
	// apb
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// power and interrupts
	input wire logic        cpu_sleep,
	input wire logic        cpu_idle,
	input wire logic [1:0]  capture_irq,
	input wire logic        wake_req
);
	logic [1:0]  en_r;
	logic [15:0] c1_r, c2_r;
	wire logic   acc_w = psel && penable && pready;
	wire logic   con1_w = paddr == 12'(`ICU_IDX_CON1 * 4);
	wire logic   con2_w = paddr == 12'(`ICU_IDX_CON2 * 4);
	wire logic   en_w = paddr == 12'(`ICU_IDX_IRQ_EN * 4);
	wire logic   map_w = con1_w || con2_w || en_w || paddr == 12'(`ICU_IDX_BUF1 * 4)
		|| paddr == 12'(`ICU_IDX_BUF2 * 4) || paddr == 12'(`ICU_IDX_IRQ_STAT * 4);
	wire logic   rdc_w = acc_w && !pwrite && (con1_w || con2_w);

	// shadow of software-owned fields
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_r <= 2'h0;
			c1_r <= 16'h0000;
			c2_r <= 16'h0000;
		end else if (acc_w && pwrite) begin
			if (en_w)
				en_r <= pwdata[1:0];
			if (con1_w)
				c1_r <= pwdata[15:0] & 16'h20e7;
			if (con2_w)
				c2_r <= pwdata[15:0] & 16'h20e7;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	err_phase_a: assert property (pslverr |-> psel && penable)
		else $error("slave error outside access");
	err_map_a: assert property (psel && penable |-> pslverr == !map_w)
		else $error("slave error wrong for address");
	upper_zero_a: assert property (acc_w && !pwrite |-> prdata[31:16] == 16'h0)
		else $error("upper read bits set");
	ctrl_fields_a: assert property (rdc_w |-> (prdata[15:0] & 16'h20e7) == (con1_w ? c1_r : c2_r))
		else $error("control fields differ");
	rsvd_bits_a: assert property (rdc_w |-> (prdata[15:0] & 16'hdf00) == 16'h0)
		else $error("reserved control bits set");
	irq_masked_a: assert property ((capture_irq & ~(en_r | $past(en_r))) == 2'h0)
		else $error("interrupt while disabled");
	wake_state_a: assert property (wake_req |-> $past(cpu_sleep || cpu_idle) || $past(cpu_sleep || cpu_idle, 2))
		else $error("wake while running");
	wake_en_a: assert property (wake_req |-> en_r != 2'h0 || $past(en_r) != 2'h0)
		else $error("wake without enable");
	wake_pulse_a: assert property (wake_req |=> !wake_req)
		else $error("wake longer than a cycle");
endmodule

bind icu_top icu_top_chk u_icu_top_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .cpu_sleep, .cpu_idle, .capture_irq, .wake_req);

`default_nettype wire

// *** sim/input_capture_unit_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "icu_cfg.svh"

module input_capture_unit_bench
	import icu_pkg::*;
;
	localparam logic [11:0] A_STAT = 12'(`ICU_IDX_IRQ_STAT * 4);
	localparam logic [11:0] A_EN   = 12'(`ICU_IDX_IRQ_EN * 4);

	logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, err, wake_req, busy, go = 1'h0, src_ch = 1'h0;
	logic [1:0]  cap_pin, capture_irq;
	logic [15:0] timebase_a_count = 16'h0, timebase_b_count = 16'h0;
	logic        timebase_a_run = 1'h0, timebase_b_run = 1'h0, cpu_sleep = 1'h0, cpu_idle = 1'h0;
	logic [15:0] exp_q [$];
	int          bad_count = 0, n_tests = 0, n_wake = 0, seed = 49;

	always #2 pclk = ~pclk;
	always @(posedge pclk)
		if (wake_req === 1'h1)
			n_wake <= n_wake + 1;

	icu_top u_icu_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .cap_pin, .timebase_a_count, .timebase_a_run, .timebase_b_count, .timebase_b_run,
		.cpu_sleep, .cpu_idle, .capture_irq, .wake_req);
	icu_src u_icu_src (.pclk, .go, .ch(src_ch), .pin(cap_pin), .busy);

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic tmo(input logic ok);
		if (!ok) begin
			bad_count++;
			$display("BAD wait expected done seen timeout");
			give_verdict();
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'h1 && k < 20);
		tmo(pready === 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic pulse(input logic c);
		int k;
		@(posedge pclk);
		go <= 1'h1;
		src_ch <= c;
		@(posedge pclk);
		go <= 1'h0;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (busy !== 1'h0 && k < 40);
		tmo(busy === 1'h0);
	endtask

	// captures made by the r-th pulse, counting both of its edges
	function automatic int hits(input icu_mode_t m, input int r);
		case (m)
			ICU_FALL, ICU_RISE: return 1;
			ICU_BOTH: return 2;
			ICU_RISE4: return int'(r % 4 == 0);
			ICU_RISE16: return int'(r % 16 == 0);
			default: return 0;
		endcase
	endfunction

	function automatic logic [11:0] acon(input logic c);
		return 12'((`ICU_IDX_CON1 + (c ? `ICU_IDX_CH_STEP : 12'h0)) * 4);
	endfunction

	function automatic logic [11:0] abuf(input logic c);
		return 12'((`ICU_IDX_BUF1 + (c ? `ICU_IDX_CH_STEP : 12'h0)) * 4);
	endfunction

	task automatic run(input logic c, input icu_mode_t m, input logic [1:0] n, input int p,
		input logic slp, input logic idl, input logic mid);
		logic [15:0] con, v, va, vb;
		logic        sel, sidl, en, runa, runb, act, ovf, flg;
		int          r, st, ew, w0;
		sel = 1'($random(seed));
		sidl = 1'($random(seed));
		runa = 1'($random(seed));
		runb = 1'($random(seed));
		en = m == ICU_IRQ_ONLY || 1'($random(seed));
		apb(1'h1, acon(c), 32'h0);
		apb(1'h1, A_STAT, 32'h3);
		apb(1'h1, A_EN, {30'h0, en & c, en & !c});
		timebase_a_run <= runa;
		timebase_b_run <= runb;
		cpu_sleep <= slp;
		cpu_idle <= idl;
		con = {2'h0, sidl, 5'h0, sel, n, 2'h0, m};
		apb(1'h1, acon(c), {16'h0, con});
		apb(1'h0, acon(c), 32'h0);
		chk("control", {16'h0, con}, rd);
		act = m == ICU_IRQ_ONLY || (!slp && (!idl || (!sidl && (sel ? runa : runb))));
		r = 0;
		st = 0;
		ew = 0;
		ovf = 0;
		flg = 0;
		w0 = n_wake;
		exp_q.delete();
		for (int i = 0; i < p + int'(mid); i++) begin
			if (i == p) begin
				apb(1'h0, abuf(c), 32'h0);
				chk("buffer", {16'h0, exp_q.pop_front()}, rd);
			end
			va = 16'($random(seed));
			vb = 16'($random(seed));
			timebase_a_count <= va;
			timebase_b_count <= vb;
			v = sel ? va : vb;
			pulse(c);
			r++;
			if (m == ICU_IRQ_ONLY) begin
				flg = 1;
				ew += int'(en && (slp || idl));
			end
			for (int h = 0; h < (act ? hits(m, r) : 0); h++) begin
				if (exp_q.size() == 4)
					ovf |= m != ICU_BOTH;
				else if (!(ovf && exp_q.size() > 0)) begin
					exp_q.push_back(v);
					st++;
					flg |= st % (n + 1) == 0;
				end
				flg |= m == ICU_BOTH;
			end
		end
		chk("wake count", w0 + ew, n_wake);
		apb(1'h0, A_STAT, 32'h0);
		chk("irq flag", {31'h0, flg}, {31'h0, rd[c]});
		chk("irq line", {31'h0, flg & en}, {31'h0, capture_irq[c]});
		con[4] = ovf;
		con[3] = exp_q.size() > 0;
		apb(1'h0, acon(c), 32'h0);
		chk("status bits", {16'h0, con}, rd);
		while (exp_q.size() > 0) begin
			apb(1'h0, abuf(c), 32'h0);
			chk("buffer", {16'h0, exp_q.pop_front()}, rd);
		end
		con[3] = 1'h0;
		apb(1'h0, acon(c), 32'h0);
		chk("drained", {16'h0, con}, rd);
		$display("test mode %0d ch %0d done", m, c);
	endtask

	initial begin
		logic [11:0] ra [4];
		logic        s;
		ra = '{acon(1'h0), acon(1'h1), A_STAT, A_EN};
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		foreach (ra[i]) begin
			apb(1'h0, ra[i], 32'h0);
			chk("reset value", 32'h0, rd);
		end
		apb(1'h0, 12'h530, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
		chk("unmapped data", 32'h0, rd);
		$display("test reset and map done");
		run(1'h0, ICU_RISE, 2'h0, 3, 1'h0, 1'h0, 1'h0);
		run(1'h1, ICU_FALL, 2'h1, 2, 1'h0, 1'h0, 1'h0);
		run(1'h0, ICU_RISE4, 2'h0, 3, 1'h0, 1'h0, 1'h0);
		run(1'h0, ICU_RISE4, 2'h0, 5, 1'h0, 1'h0, 1'h0);
		run(1'h1, ICU_RISE16, 2'h3, 16, 1'h0, 1'h0, 1'h0);
		run(1'h0, ICU_BOTH, 2'h3, 3, 1'h0, 1'h0, 1'h0);
		run(1'h1, ICU_RISE, 2'h1, 6, 1'h0, 1'h0, 1'h1);
		run(1'h0, ICU_IRQ_ONLY, 2'h0, 2, 1'h1, 1'h0, 1'h0);
		run(1'h1, ICU_IRQ_ONLY, 2'h2, 1, 1'h0, 1'h1, 1'h0);
		run(1'h0, ICU_RISE, 2'h0, 2, 1'h1, 1'h0, 1'h0);
		run(1'h1, ICU_RISE4, 2'h1, 4, 1'h0, 1'h1, 1'h0);
		repeat (8) begin
			s = 1'($random(seed));
			run(1'($random(seed)), icu_mode_t'(3'($random(seed))), 2'($random(seed)),
				1 + {$random(seed)} % 6, s, !s && 1'($random(seed)), 1'h0);
		end
		give_verdict();
	end
endmodule

`default_nettype wire
